// file: hdl/gp_timer_pkg.sv
// Purpose: Shared constants for the general-purpose timer block.
// Assumes: 16-bit control, period and count registers on 32-bit APB words.
// Notes: Offsets are byte addresses within the block window.
package gp_timer_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_A_CTRL = 8'h00;
  localparam logic [7:0] OFS_A_PERIOD = 8'h04;
  localparam logic [7:0] OFS_A_COUNT = 8'h08;
  localparam logic [7:0] OFS_LO_CTRL = 8'h0C;
  localparam logic [7:0] OFS_LO_PERIOD = 8'h10;
  localparam logic [7:0] OFS_LO_COUNT = 8'h14;
  localparam logic [7:0] OFS_HI_CTRL = 8'h18;
  localparam logic [7:0] OFS_HI_PERIOD = 8'h1C;
  localparam logic [7:0] OFS_HI_COUNT = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int BIT_RUN = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int BIT_ECS_HI = 9;
  localparam int BIT_ECS_LO = 8;
  localparam int BIT_GATE = 6;
  localparam int BIT_PRESC_HI = 5;
  localparam int BIT_PRESC_LO = 4;
  localparam int BIT_JOIN = 3;
  localparam int BIT_SYNC = 2;
  localparam int BIT_CS = 1;
  localparam logic [15:0] A_CTRL_MASK = 16'hA376;
  localparam logic [15:0] LO_CTRL_MASK = 16'hA37A;
  localparam logic [15:0] HI_CTRL_MASK = 16'hA372;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // Prescale terminal counts and interrupt bits
  // ----------------------------------------------------------------
  localparam logic [7:0] PRESC_LIM_1 = 8'h00;
  localparam logic [7:0] PRESC_LIM_8 = 8'h07;
  localparam logic [7:0] PRESC_LIM_64 = 8'h3F;
  localparam logic [7:0] PRESC_LIM_256 = 8'hFF;
  localparam int IRQ_A = 0;
  localparam int IRQ_LO = 1;
  localparam int IRQ_HI = 2;
  localparam int IRQ_W = 3;
  typedef enum logic [1:0] {
    SRC_SECONDARY = 2'b00,
    SRC_OWN_PIN = 2'b01,
    SRC_LOW_POWER_RC = 2'b10,
    SRC_GENERIC = 2'b11
  } ext_src_e;
endpackage : gp_timer_pkg

// file: hdl/tick_if.sv
// Purpose: Carries one timer's clocking setup and its prescaled tick.
// Assumes: Driven by the timer top, consumed by tick_gen.
// Notes: extIn is indexed by the extended-source code.
`timescale 1ns/100ps
interface tick_if;
  logic run;
  logic useExt;
  logic [1:0] extSel;
  logic gateEn;
  logic [1:0] presc;
  logic syncSel;
  logic ctrlWrite;
  logic [3:0] extIn;
  logic gate;
  logic tick;
  logic gateFall;
  modport gen (
    input run, useExt, extSel, gateEn, presc, syncSel, ctrlWrite,
    input extIn, gate,
    output tick, gateFall
  );
  modport user (
    output run, useExt, extSel, gateEn, presc, syncSel, ctrlWrite,
    output extIn, gate,
    input tick, gateFall
  );
endinterface : tick_if

// file: hdl/tick_gen.sv
// Purpose: Clock source select, sync, gating and prescale for one timer.
// Assumes: External sources are sampled levels on clk.
// Notes: ASYNC_OK lets the sync-select bit bypass the synchroniser.
`timescale 1ns/100ps
module tick_gen #(
  parameter bit ASYNC_OK = 1'b0
) (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  tick_if.gen tk // setup in, tick out
);
  logic half_q, extS1_q, extS2_q, extPrev_q, gatePrev_q;
  logic tick_q, gateFall_q;
  logic [7:0] pre_q;
  logic [7:0] preLim;
  logic extLevel, srcEdge, countable;

  assign extLevel = (ASYNC_OK && !tk.syncSel) ? tk.extIn[tk.extSel]
                                              : extS2_q; // R8 R15
  assign srcEdge = tk.useExt ? (extLevel && !extPrev_q) : half_q; // R4 R5
  assign countable = srcEdge && (tk.useExt || !tk.gateEn || tk.gate); // R6
  assign tk.tick = tick_q;
  assign tk.gateFall = gateFall_q;

  always_comb begin
    case (tk.presc) // R3
      2'b00: preLim = gp_timer_pkg::PRESC_LIM_1;
      2'b01: preLim = gp_timer_pkg::PRESC_LIM_8;
      2'b10: preLim = gp_timer_pkg::PRESC_LIM_64;
      default: preLim = gp_timer_pkg::PRESC_LIM_256;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      half_q <= 1'b0;
      extS1_q <= 1'b0;
      extS2_q <= 1'b0;
      extPrev_q <= 1'b0;
      gatePrev_q <= 1'b0;
    end else begin
      half_q <= !half_q; // Internal source runs at half the clock
      extS1_q <= tk.extIn[tk.extSel];
      extS2_q <= extS1_q;
      extPrev_q <= extLevel;
      gatePrev_q <= tk.gate;
    end
  end

  // Prescaler cleared while halted so a restart begins a full interval
  always_ff @(posedge clk) begin
    if (srst || !tk.run || tk.ctrlWrite) begin // R1 R2 R16
      pre_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (countable) begin
        if (pre_q >= preLim) begin
          pre_q <= 8'h00;
          tick_q <= 1'b1;
        end else begin
          pre_q <= pre_q + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      gateFall_q <= 1'b0;
    end else begin
      gateFall_q <= tk.run && !tk.useExt && tk.gateEn &&
                    gatePrev_q && !tk.gate; // R7
    end
  end
endmodule : tick_gen

// file: hdl/irq_bank.sv
// Purpose: Sticky event flags, mask and one level interrupt.
// Assumes: Write-one-to-clear on the status word.
// Notes: A set in the clearing cycle wins over the clear.
`timescale 1ns/100ps
module irq_bank #(
  parameter int N = 3
) (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic [N-1:0] setEv, // one-cycle event pulses
  input wire logic clrWr, // status write strobe
  input wire logic maskWr, // mask write strobe
  input wire logic [N-1:0] wrData, // write data
  output logic [N-1:0] status, // sticky flags
  output logic [N-1:0] mask, // enable bits
  output logic irq // level interrupt
);
  always_ff @(posedge clk) begin
    if (srst) begin
      status <= '0;
      mask <= '0;
      irq <= 1'b0;
    end else begin
      status <= (status & ~(clrWr ? wrData : '0)) | setEv;
      if (maskWr) begin
        mask <= wrData;
      end
      irq <= |(status & mask);
    end
  end
endmodule : irq_bank

// file: hdl/gp_timers.sv
// Purpose: Standalone 16-bit timer plus a joinable 16/32-bit timer pair.
// Assumes: APB slave with no wait states; pins sampled on clk.
// Notes: Contract
// Contract
// R1 - Timer counts only while run bit set
// R2 - Idle-stop bit suspends timer in Idle
// R3 - Prescale codes divide by 1, 8, 64, 256
// R4 - Clock-source bit picks internal or extended source
// R5 - Extended field picks generic, RC, own pin
// R6 - Gate counts internal clock only while gate high
// R7 - Standalone irq on period match, gate fall
// R8 - Sync bit synchronises standalone external clock
// R9 - Join bit makes pair one 32-bit timer
// R10 - Low timer holds low word of count
// R11 - Joined timer uses only low timer setup
// R12 - Joined match raises high timer flag only
// R13 - High period gives upper joined period word
// R14 - A/D trigger from pair high or joined
// R15 - Pair timers never count asynchronously
// R16 - Control write while running clears prescaler
// R17 - Software sets up joined timer before run
// R18 - High control ignored while pair joined
// R19 - Increment per tick, wrap after period match
`timescale 1ns/100ps
module gp_timers (
  input wire logic clk, // system clock, 40 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic idleMode, // device in Idle mode
  input wire logic timerAExtClockPin, // standalone timer clock pin
  input wire logic pairLowExtClockPin, // pair low timer clock pin
  input wire logic pairHighExtClockPin, // pair high timer clock pin
  input wire logic genericExtClockPin, // shared external input
  input wire logic lowPowerRcOsc, // low-power RC oscillator
  input wire logic secondaryOsc, // secondary oscillator
  input wire logic timerAGate, // standalone gate input
  input wire logic pairLowGate, // pair low gate input
  input wire logic pairHighGate, // pair high gate input
  output logic irq, // level interrupt
  output logic adcTrigger // A/D event trigger pulse
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [15:0] aCtrl_q, loCtrl_q, hiCtrl_q;
  logic [15:0] aPeriod_q, loPeriod_q, hiPeriod_q;
  logic [15:0] aCount_q, loCount_q, hiCount_q;
  logic aMatch_q, loMatch_q, hiMatch_q;
  logic pready_q, pslverr_q, adcTrigger_q;
  logic [31:0] prdata_q;
  logic [gp_timer_pkg::IRQ_W-1:0] irqStatus, irqMask, irqSet;
  logic irqLine;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic busWr, joined;
  logic wrACtrl, wrAPer, wrACnt, wrLoCtrl, wrLoPer, wrLoCnt;
  logic wrHiCtrl, wrHiPer, wrHiCnt, wrStatus, wrMask;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, gp_timer_pkg::OFS_A_CTRL) ||
             hit(a, gp_timer_pkg::OFS_A_PERIOD) ||
             hit(a, gp_timer_pkg::OFS_A_COUNT) ||
             hit(a, gp_timer_pkg::OFS_LO_CTRL) ||
             hit(a, gp_timer_pkg::OFS_LO_PERIOD) ||
             hit(a, gp_timer_pkg::OFS_LO_COUNT) ||
             hit(a, gp_timer_pkg::OFS_HI_CTRL) ||
             hit(a, gp_timer_pkg::OFS_HI_PERIOD) ||
             hit(a, gp_timer_pkg::OFS_HI_COUNT) ||
             hit(a, gp_timer_pkg::OFS_IRQ_STATUS) ||
             hit(a, gp_timer_pkg::OFS_IRQ_MASK);
  endfunction : mapped

  assign busWr = psel && penable && pready_q && pwrite;
  assign wrACtrl = busWr && hit(paddr, gp_timer_pkg::OFS_A_CTRL);
  assign wrAPer = busWr && hit(paddr, gp_timer_pkg::OFS_A_PERIOD);
  assign wrACnt = busWr && hit(paddr, gp_timer_pkg::OFS_A_COUNT);
  assign wrLoCtrl = busWr && hit(paddr, gp_timer_pkg::OFS_LO_CTRL);
  assign wrLoPer = busWr && hit(paddr, gp_timer_pkg::OFS_LO_PERIOD);
  assign wrLoCnt = busWr && hit(paddr, gp_timer_pkg::OFS_LO_COUNT);
  assign wrHiCtrl = busWr && hit(paddr, gp_timer_pkg::OFS_HI_CTRL);
  assign wrHiPer = busWr && hit(paddr, gp_timer_pkg::OFS_HI_PERIOD);
  assign wrHiCnt = busWr && hit(paddr, gp_timer_pkg::OFS_HI_COUNT);
  assign wrStatus = busWr && hit(paddr, gp_timer_pkg::OFS_IRQ_STATUS);
  assign wrMask = busWr && hit(paddr, gp_timer_pkg::OFS_IRQ_MASK);
  assign joined = loCtrl_q[gp_timer_pkg::BIT_JOIN]; // R9

  // ----------------------------------------------------------------
  // APB answer: ready in the first access cycle
  // ----------------------------------------------------------------
  logic [31:0] readMux;

  always_comb begin
    readMux = 32'h0000_0000;
    case (paddr)
      gp_timer_pkg::OFS_A_CTRL: readMux[15:0] = aCtrl_q;
      gp_timer_pkg::OFS_A_PERIOD: readMux[15:0] = aPeriod_q;
      gp_timer_pkg::OFS_A_COUNT: readMux[15:0] = aCount_q;
      gp_timer_pkg::OFS_LO_CTRL: readMux[15:0] = loCtrl_q;
      gp_timer_pkg::OFS_LO_PERIOD: readMux[15:0] = loPeriod_q;
      gp_timer_pkg::OFS_LO_COUNT: readMux[15:0] = loCount_q;
      gp_timer_pkg::OFS_HI_CTRL: readMux[15:0] = hiCtrl_q;
      gp_timer_pkg::OFS_HI_PERIOD: readMux[15:0] = hiPeriod_q;
      gp_timer_pkg::OFS_HI_COUNT: readMux[15:0] = hiCount_q;
      gp_timer_pkg::OFS_IRQ_STATUS:
        readMux[gp_timer_pkg::IRQ_W-1:0] = irqStatus;
      gp_timer_pkg::OFS_IRQ_MASK:
        readMux[gp_timer_pkg::IRQ_W-1:0] = irqMask;
      default: readMux = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup cycle, so counts read one
  // clock before the transfer completes
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !mapped(paddr);
      if (psel && !penable) begin
        prdata_q <= pwrite ? 32'h0000_0000 : readMux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and period registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      aCtrl_q <= gp_timer_pkg::CTRL_RESET;
      loCtrl_q <= gp_timer_pkg::CTRL_RESET;
      hiCtrl_q <= gp_timer_pkg::CTRL_RESET;
    end else begin
      if (wrACtrl) begin
        aCtrl_q <= pwdata[15:0] & gp_timer_pkg::A_CTRL_MASK;
      end
      if (wrLoCtrl) begin
        loCtrl_q <= pwdata[15:0] & gp_timer_pkg::LO_CTRL_MASK;
      end
      if (wrHiCtrl) begin
        hiCtrl_q <= pwdata[15:0] & gp_timer_pkg::HI_CTRL_MASK;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      aPeriod_q <= gp_timer_pkg::PERIOD_RESET;
      loPeriod_q <= gp_timer_pkg::PERIOD_RESET;
      hiPeriod_q <= gp_timer_pkg::PERIOD_RESET;
    end else begin
      if (wrAPer) begin
        aPeriod_q <= pwdata[15:0];
      end
      if (wrLoPer) begin
        loPeriod_q <= pwdata[15:0];
      end
      if (wrHiPer) begin
        hiPeriod_q <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Tick generators
  // ----------------------------------------------------------------
  tick_if aTk ();
  tick_if loTk ();
  tick_if hiTk ();

  assign aTk.run = aCtrl_q[gp_timer_pkg::BIT_RUN] && // R1 R2
                   !(aCtrl_q[gp_timer_pkg::BIT_IDLE_STOP] && idleMode);
  assign aTk.useExt = aCtrl_q[gp_timer_pkg::BIT_CS];
  assign aTk.extSel = aCtrl_q[gp_timer_pkg::BIT_ECS_HI:
                              gp_timer_pkg::BIT_ECS_LO];
  assign aTk.gateEn = aCtrl_q[gp_timer_pkg::BIT_GATE];
  assign aTk.presc = aCtrl_q[gp_timer_pkg::BIT_PRESC_HI:
                             gp_timer_pkg::BIT_PRESC_LO];
  assign aTk.syncSel = aCtrl_q[gp_timer_pkg::BIT_SYNC];
  assign aTk.ctrlWrite = wrACtrl && aCtrl_q[gp_timer_pkg::BIT_RUN]; // R16
  assign aTk.extIn = {genericExtClockPin, lowPowerRcOsc,
                      timerAExtClockPin, secondaryOsc}; // R5
  assign aTk.gate = timerAGate;

  // Low timer setup also governs the joined pair
  assign loTk.run = loCtrl_q[gp_timer_pkg::BIT_RUN] && // R11
                    !(loCtrl_q[gp_timer_pkg::BIT_IDLE_STOP] && idleMode);
  assign loTk.useExt = loCtrl_q[gp_timer_pkg::BIT_CS];
  assign loTk.extSel = loCtrl_q[gp_timer_pkg::BIT_ECS_HI:
                                gp_timer_pkg::BIT_ECS_LO];
  assign loTk.gateEn = loCtrl_q[gp_timer_pkg::BIT_GATE];
  assign loTk.presc = loCtrl_q[gp_timer_pkg::BIT_PRESC_HI:
                               gp_timer_pkg::BIT_PRESC_LO];
  assign loTk.syncSel = 1'b1;
  assign loTk.ctrlWrite = wrLoCtrl && loCtrl_q[gp_timer_pkg::BIT_RUN]; // R16
  assign loTk.extIn = {genericExtClockPin, lowPowerRcOsc,
                       pairLowExtClockPin, secondaryOsc};
  assign loTk.gate = pairLowGate;

  // High timer is held off while joined
  assign hiTk.run = !joined && hiCtrl_q[gp_timer_pkg::BIT_RUN] && // R18
                    !(hiCtrl_q[gp_timer_pkg::BIT_IDLE_STOP] && idleMode);
  assign hiTk.useExt = hiCtrl_q[gp_timer_pkg::BIT_CS];
  assign hiTk.extSel = hiCtrl_q[gp_timer_pkg::BIT_ECS_HI:
                                gp_timer_pkg::BIT_ECS_LO];
  assign hiTk.gateEn = hiCtrl_q[gp_timer_pkg::BIT_GATE];
  assign hiTk.presc = hiCtrl_q[gp_timer_pkg::BIT_PRESC_HI:
                               gp_timer_pkg::BIT_PRESC_LO];
  assign hiTk.syncSel = 1'b1;
  assign hiTk.ctrlWrite = wrHiCtrl && hiCtrl_q[gp_timer_pkg::BIT_RUN]; // R16
  assign hiTk.extIn = {genericExtClockPin, lowPowerRcOsc,
                       pairHighExtClockPin, secondaryOsc};
  assign hiTk.gate = pairHighGate;

  tick_gen #(.ASYNC_OK(1'b1)) aGen (
    .clk(clk),
    .srst(srst),
    .tk(aTk)
  );

  // Pair generators have no asynchronous path
  tick_gen #(.ASYNC_OK(1'b0)) loGen ( // R15
    .clk(clk),
    .srst(srst),
    .tk(loTk)
  );

  tick_gen #(.ASYNC_OK(1'b0)) hiGen (
    .clk(clk),
    .srst(srst),
    .tk(hiTk)
  );

  // ----------------------------------------------------------------
  // Standalone counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      aCount_q <= gp_timer_pkg::COUNT_RESET;
      aMatch_q <= 1'b0;
    end else begin
      aMatch_q <= 1'b0;
      if (wrACnt) begin
        aCount_q <= pwdata[15:0];
      end else if (aTk.tick) begin
        if (aCount_q == aPeriod_q) begin // R19
          aCount_q <= 16'h0000;
          aMatch_q <= 1'b1; // R7
        end else begin
          aCount_q <= aCount_q + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pair counters
  // ----------------------------------------------------------------
  logic match32, loWrapCarry;

  assign match32 = {hiCount_q, loCount_q} == {hiPeriod_q, loPeriod_q}; // R13
  assign loWrapCarry = loCount_q == 16'hFFFF;

  always_ff @(posedge clk) begin
    if (srst) begin
      loCount_q <= gp_timer_pkg::COUNT_RESET;
      loMatch_q <= 1'b0;
    end else begin
      loMatch_q <= 1'b0;
      if (wrLoCnt) begin
        loCount_q <= pwdata[15:0];
      end else if (loTk.tick) begin
        if (joined ? match32 : (loCount_q == loPeriod_q)) begin
          loCount_q <= 16'h0000;
          loMatch_q <= !joined; // R12
        end else begin
          loCount_q <= loCount_q + 16'h0001; // R10
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hiCount_q <= gp_timer_pkg::COUNT_RESET;
      hiMatch_q <= 1'b0;
    end else begin
      hiMatch_q <= 1'b0;
      if (wrHiCnt) begin
        hiCount_q <= pwdata[15:0];
      end else if (joined) begin
        if (loTk.tick) begin
          if (match32) begin
            hiCount_q <= 16'h0000;
            hiMatch_q <= 1'b1; // R12
          end else if (loWrapCarry) begin
            hiCount_q <= hiCount_q + 16'h0001; // R10
          end
        end
      end else if (hiTk.tick) begin
        if (hiCount_q == hiPeriod_q) begin
          hiCount_q <= 16'h0000;
          hiMatch_q <= 1'b1;
        end else begin
          hiCount_q <= hiCount_q + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts and A/D trigger
  // ----------------------------------------------------------------
  assign irqSet[gp_timer_pkg::IRQ_A] = aMatch_q || aTk.gateFall; // R7
  assign irqSet[gp_timer_pkg::IRQ_LO] = loMatch_q;
  assign irqSet[gp_timer_pkg::IRQ_HI] = hiMatch_q;

  irq_bank #(.N(gp_timer_pkg::IRQ_W)) irqs (
    .clk(clk),
    .srst(srst),
    .setEv(irqSet),
    .clrWr(wrStatus),
    .maskWr(wrMask),
    .wrData(pwdata[gp_timer_pkg::IRQ_W-1:0]),
    .status(irqStatus),
    .mask(irqMask),
    .irq(irqLine)
  );

  // Only the high half or joined pair may fire the converter
  always_ff @(posedge clk) begin
    if (srst) begin
      adcTrigger_q <= 1'b0;
    end else begin
      adcTrigger_q <= hiMatch_q; // R14
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irqLine;
  assign adcTrigger = adcTrigger_q;
endmodule : gp_timers

// file: test/gp_timers_props.sv
// Purpose: Port-level checks on the timer block.
// Assumes: Single clock domain, srst synchronous high.
// Notes: Bound into every gp_timers instance.
`timescale 1ns/100ps
module gp_timers_props (
  input wire logic clk, // clock
  input wire logic srst, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic irq, // interrupt
  input wire logic adcTrigger // trigger
);
  logic wrDone;
  assign wrDone = psel & penable & pwrite & pready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----
  // Checks
  // ----
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_adc_pulse: assert property (adcTrigger |=> !adcTrigger)
    else $error("trigger wider than a pulse");
  a_irq_clear_cause: assert property ($fell(irq) |-> $past(wrDone, 2))
    else $error("interrupt dropped without a write");
  a_reset_quiet: assert property ($fell(srst) |-> !irq && !adcTrigger)
    else $error("outputs active after reset");
  c_irq: cover property ($rose(irq));
  c_adc: cover property (adcTrigger);
  c_err: cover property (pslverr);
endmodule : gp_timers_props
bind gp_timers gp_timers_props chk (.clk(clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq), .adcTrigger(adcTrigger));

// file: test/ext_clock_model.sv
// Purpose: Far-side clock source feeding one timer input pin.
// Assumes: Sampled on the system clock.
// Notes: Pin rests low while not running.
`timescale 1ns/100ps
module ext_clock_model #(
  parameter int HALF = 2
) (
  input wire logic clk, // system clock
  input wire logic run, // source active
  output logic pin = 1'b0 // generated clock
);
  int cnt = 0;
  always @(posedge clk) begin
    if (!run) begin
      cnt <= 0;
      pin <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      pin <= !pin;
    end else cnt <= cnt + 1;
  end
endmodule : ext_clock_model

// file: test/gp_timers_tb.sv
// Purpose: Self-checking bench for the timer block.
// Assumes: APB waits end only by the bench timeout.
// Notes: Period-match spacing is measured on adcTrigger.
`timescale 1ns/100ps
module gp_timers_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, irq, adcTrigger, lastErr;
  logic idleMode = 1'b0;
  logic gateA = 1'b0;
  logic extRun = 1'b0;
  wire logic [3:0] src;
  logic [15:0] lfsr = 16'h984B;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  int dv[4] = '{1, 8, 64, 256};
  int p, g;
  int expQ[$];
  initial forever #12.5 clk = ~clk;
  for (genvar i = 0; i < 4; i++) begin : g_src
    ext_clock_model #(.HALF(i + 2)) m (.clk(clk), .run(extRun),
      .pin(src[i]));
  end
  gp_timers dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .idleMode(idleMode),
    .timerAExtClockPin(src[1]), .pairLowExtClockPin(src[1]),
    .pairHighExtClockPin(src[1]), .genericExtClockPin(src[3]),
    .lowPowerRcOsc(src[2]), .secondaryOsc(src[0]), .timerAGate(gateA),
    .pairLowGate(1'b0), .pairHighGate(1'b0), .irq(irq),
    .adcTrigger(adcTrigger));
  // ----
  // Tasks
  // ----
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic check(string s, logic [31:0] v, logic [31:0] e);
    compares++;
    if (v !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", s, e, v);
    end
  endtask : check
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rd(logic [7:0] a, logic [31:0] e, string s);
    bus(1'b0, a, 32'h0);
    check(s, rdat, e);
  endtask : rd
  // Spacing between two match pulses; first pulse may be partial
  task automatic gap(output int n);
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (adcTrigger !== 1'b1 && n < 6000);
    end
  endtask : gap
  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      finish_test();
    end
  end
  // ----
  // Sequence
  // ----
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(gp_timer_pkg::OFS_A_PERIOD, 32'hFFFF, "period");
    rd(gp_timer_pkg::OFS_HI_CTRL, 32'h0, "ctrl");
    rd(8'h30, 32'h0, "unmapped");
    check("slverr", lastErr, 1'b1);
    $display("test registers done");
    lfsr = lfsr_next(lfsr);
    p = int'(lfsr[1:0]) + 1;
    bus(1'b1, gp_timer_pkg::OFS_HI_PERIOD, p);
    for (int k = 0; k < 8; k++) begin
      extRun <= (k > 3);
      bus(1'b1, gp_timer_pkg::OFS_HI_CTRL,
        k < 4 ? 32'h8000 | (k << 4) : 32'h8042 | ((k - 4) << 8));
      expQ.push_back((p + 1) * 2 * (k < 4 ? dv[k] : k - 2));
      gap(g);
      check("gap", g, expQ.pop_front());
    end
    $display("test sources done");
    extRun <= 1'b0;
    idleMode <= 1'b1;
    bus(1'b1, gp_timer_pkg::OFS_HI_CTRL, 32'hA000);
    repeat (4) @(posedge clk);
    g = 0;
    repeat (60) begin
      @(posedge clk);
      if (adcTrigger !== 1'b0) g++;
    end
    check("idle", g, 0);
    bus(1'b1, gp_timer_pkg::OFS_HI_CTRL, 32'h8000);
    gap(g);
    check("noidle", g, (p + 1) * 2);
    idleMode <= 1'b0;
    // High timer left running 1:256 must not govern the joined pair
    bus(1'b1, gp_timer_pkg::OFS_HI_CTRL, 32'h8030);
    bus(1'b1, gp_timer_pkg::OFS_LO_CTRL, 32'h0008);
    bus(1'b1, gp_timer_pkg::OFS_LO_PERIOD, 32'h0);
    bus(1'b1, gp_timer_pkg::OFS_HI_PERIOD, 32'h1);
    bus(1'b1, gp_timer_pkg::OFS_LO_COUNT, 32'hFFF8);
    bus(1'b1, gp_timer_pkg::OFS_HI_COUNT, 32'h0);
    bus(1'b1, gp_timer_pkg::OFS_IRQ_STATUS, 32'h7);
    bus(1'b1, gp_timer_pkg::OFS_IRQ_MASK, 32'h4);
    bus(1'b1, gp_timer_pkg::OFS_LO_CTRL, 32'h8008);
    g = 0;
    while (irq !== 1'b1 && g < 100) begin
      @(posedge clk);
      g++;
    end
    check("joinirq", irq, 1'b1);
    rd(gp_timer_pkg::OFS_IRQ_STATUS, 32'h4, "joinst");
    $display("test joined done");
    bus(1'b1, gp_timer_pkg::OFS_LO_CTRL, 32'h0);
    bus(1'b1, gp_timer_pkg::OFS_IRQ_MASK, 32'h0);
    bus(1'b1, gp_timer_pkg::OFS_IRQ_STATUS, 32'h7);
    bus(1'b1, gp_timer_pkg::OFS_A_CTRL, 32'h8040);
    repeat (20) @(posedge clk);
    rd(gp_timer_pkg::OFS_A_COUNT, 32'h0, "gated");
    gateA <= 1'b1;
    repeat (9) @(posedge clk);
    gateA <= 1'b0;
    repeat (6) @(posedge clk);
    rd(gp_timer_pkg::OFS_IRQ_STATUS, 32'h1, "gatefall");
    check("masked", irq, 1'b0);
    bus(1'b1, gp_timer_pkg::OFS_IRQ_MASK, 32'h1);
    @(posedge clk);
    check("irq", irq, 1'b1);
    bus(1'b1, gp_timer_pkg::OFS_IRQ_STATUS, 32'h1);
    @(posedge clk);
    check("irqclr", irq, 1'b0);
    // Own pin, unsynchronised: about one count per six clocks
    bus(1'b1, gp_timer_pkg::OFS_A_COUNT, 32'h0);
    extRun <= 1'b1;
    bus(1'b1, gp_timer_pkg::OFS_A_CTRL, 32'h8102);
    repeat (60) @(posedge clk);
    bus(1'b0, gp_timer_pkg::OFS_A_COUNT, 32'h0);
    check("extA", rdat >= 32'd9 && rdat <= 32'd11, 1'b1);
    $display("test interrupt done");
    finish_test();
  end
endmodule : gp_timers_tb
